// ---- core/afr_core.sv ----
// file holds the fault alarm and reference select top level
//
// Notes on behaviour
// - differential overrange beyond 105 percent sets flag
// - flag reported per conversion, then cleared
// - output above supply minus 0.2V sets high
// - output below supply plus 0.2V sets low
// - high and low flags cleared each conversion
// - low reference checked continuously during conversion
// - low reference flag at status bit four
// - low reference flag cleared at conversion start
// - two independent 3-bit reference select fields
// - zero in both fields selects internal
// - bit seven of first mode reverses polarity
// - internal reference enable resets to one
// - internal reference default, independent of secondary
// - modulator strobe at clock divided by eight
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/10ps
module afr_core
    import afr_pkg::*;
#(
    parameter int DATA_W = 32
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [DATA_W-1:0]      reg_rdata,
    // conversion framing
    input  wire logic              conv_start,
    input  wire logic              conv_end,
    // analog comparators
    input  wire afr_cmp_t          cmp_in,
    // outputs
    output afr_ref_cfg_t           ref_cfg,
    output logic [7:0]             status_byte,
    output logic                   mod_strobe,
    output logic                   conv_active,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    logic       swap_r;
    logic [2:0] pos_sel_r;
    logic [2:0] neg_sel_r;
    logic       int_en_r;
    logic [3:0] irq_en_r;
    logic       run_r;
    logic       wr_mode;
    logic       wr_ref_sel;
    logic       wr_ref_ctrl;
    logic       wr_irq_en;
    logic       wr_irq_clr;
    logic       wr_run;

    // one address compare per register, shared by every update path
    assign wr_mode     = reg_wr && (reg_addr == AFR_OFS_FIRST_MODE);
    assign wr_ref_sel  = reg_wr && (reg_addr == AFR_OFS_REF_SEL);
    assign wr_ref_ctrl = reg_wr && (reg_addr == AFR_OFS_REF_CTRL);
    assign wr_irq_en   = reg_wr && (reg_addr == AFR_OFS_IRQ_EN);
    assign wr_irq_clr  = reg_wr && (reg_addr == AFR_OFS_IRQ_CLR);
    assign wr_run      = reg_wr && (reg_addr == AFR_OFS_CONV_CTRL);

    always_ff @(posedge mclk) begin
        if (rst) begin
            swap_r <= AFR_RST_SWAP;
        end else if (wr_mode) begin
            swap_r <= reg_wdata[AFR_POS_REF_SWAP];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pos_sel_r <= AFR_SEL_INTERNAL;
            neg_sel_r <= AFR_SEL_INTERNAL;
        end else if (wr_ref_sel) begin
            pos_sel_r <= reg_wdata[AFR_POS_POS_SEL +: 3];
            neg_sel_r <= reg_wdata[AFR_POS_NEG_SEL +: 3];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            int_en_r <= AFR_RST_INT_EN;
        end else if (wr_ref_ctrl) begin
            int_en_r <= reg_wdata[AFR_POS_INT_EN];
        end
    end

    // interrupt enables share the status layout
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_en_r <= 4'h0;
        end else if (wr_irq_en) begin
            irq_en_r <= reg_wdata[AFR_POS_DIFF_FLAG +: 4];
        end
    end

    // software run bit also drives conv_active; the alarm window follows conv_start and conv_end only
    always_ff @(posedge mclk) begin
        if (rst) begin
            run_r <= 1'b0;
        end else if (wr_run) begin
            run_r <= reg_wdata[AFR_POS_CONV_RUN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reference multiplexer output

    // registered so the switches never see a decode glitch
    // zero in both selects internal
    always_ff @(posedge mclk) begin
        if (rst) begin
            ref_cfg <= '{swap: AFR_RST_SWAP, pos_sel: AFR_SEL_INTERNAL,
                         neg_sel: AFR_SEL_INTERNAL, int_en: AFR_RST_INT_EN};
        end else begin
            ref_cfg.swap    <= swap_r;
            ref_cfg.pos_sel <= pos_sel_r;
            ref_cfg.neg_sel <= neg_sel_r;
            ref_cfg.int_en  <= int_en_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion window

    typedef enum logic {
        WIN_IDLE,
        WIN_OPEN
    } afr_win_t;

    afr_win_t win_r;
    afr_win_t win_nxt;
    logic     win_open;
    logic     start_p;
    logic     end_p;

    assign win_open = (win_r == WIN_OPEN);
    assign start_p  = conv_start;
    // an end with no open window is noise and reports nothing
    assign end_p    = conv_end & win_open;

    // comparators only count while a conversion runs
    always_comb begin
        win_nxt = win_r;
        case (win_r)
            WIN_IDLE: begin
                if (start_p) begin
                    win_nxt = WIN_OPEN;
                end
            end
            WIN_OPEN: begin
                // a restart keeps the window open and reloads the latches
                if (!start_p && conv_end) begin
                    win_nxt = WIN_IDLE;
                end
            end
            default: begin
                win_nxt = WIN_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            win_r <= WIN_IDLE;
        end else begin
            win_r <= win_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            conv_active <= 1'b0;
        end else begin
            conv_active <= win_open | run_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // modulator rate

    localparam int MW = $clog2(AFR_MOD_DIV);
    localparam logic [MW-1:0] MOD_LAST = MW'(AFR_MOD_DIV - 1);
    logic [MW-1:0] mod_cnt_r;

    // free running; a conversion start does not realign the phase
    // divide clock by eight
    always_ff @(posedge mclk) begin
        if (rst) begin
            mod_cnt_r  <= '0;
            mod_strobe <= 1'b0;
        end else begin
            mod_cnt_r  <= (mod_cnt_r == MOD_LAST) ? '0 : mod_cnt_r + 1'b1;
            mod_strobe <= (mod_cnt_r == MOD_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alarm latches

    logic [3:0] cmp_vec;
    logic [3:0] live_vec;
    logic [3:0] rep_vec;
    logic [3:0] cmp_gated;

    assign cmp_vec = {cmp_in.ref_low, cmp_in.amp_low,
                      cmp_in.amp_high, cmp_in.diff_over};
    // the start cycle counts too, so a one-cycle event there is kept
    // comparators gated to conversion
    assign cmp_gated = cmp_vec & {4{win_open | start_p}};

    for (genvar i = 0; i < 4; i++) begin : g_alarm
        afr_alarm_latch u_latch (
            .mclk        (mclk),
            .rst         (rst),
            .conv_start  (start_p),
            .conv_end    (end_p),
            .cmp         (cmp_gated[i]),
            .flag_live   (live_vec[i]),
            .flag_report (rep_vec[i])
        );
    end

    logic diff_overrange_flag;
    logic amp_high_flag;
    logic amp_low_flag;
    logic low_ref_flag;

    assign diff_overrange_flag = rep_vec[0];
    assign amp_high_flag       = rep_vec[1];
    assign amp_low_flag        = rep_vec[2];
    assign low_ref_flag        = rep_vec[3];

    // unused bits stay zero so software can mask by position
    // low reference at bit four
    always_ff @(posedge mclk) begin
        if (rst) begin
            status_byte <= 8'h00;
        end else begin
            status_byte <= 8'h00;
            status_byte[AFR_POS_DIFF_FLAG] <= diff_overrange_flag;
            status_byte[AFR_POS_HIGH_FLAG] <= amp_high_flag;
            status_byte[AFR_POS_LOW_FLAG]  <= amp_low_flag;
            status_byte[AFR_POS_REF_FLAG]  <= low_ref_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky on report, set wins over clear

    logic [3:0] irq_stat_r;
    logic [3:0] irq_stat_nxt;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;

    assign irq_set = end_p ? (live_vec | cmp_gated) : 4'h0;
    assign irq_clr = wr_irq_clr ? reg_wdata[AFR_POS_DIFF_FLAG +: 4] : 4'h0;
    // set is or-ed in last so an event in the clear cycle is kept
    assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_stat_r <= 4'h0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // built from the next state so the level tracks the sticky bits
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_nxt & irq_en_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port

    logic [DATA_W-1:0] rdata_nxt;

    // unmapped and write-only offsets read as zero
    always_comb begin
        rdata_nxt = '0;
        case (reg_addr)
            AFR_OFS_FIRST_MODE: begin
                rdata_nxt[AFR_POS_REF_SWAP] = swap_r;
            end
            AFR_OFS_REF_SEL: begin
                rdata_nxt[AFR_POS_POS_SEL +: 3] = pos_sel_r;
                rdata_nxt[AFR_POS_NEG_SEL +: 3] = neg_sel_r;
            end
            AFR_OFS_REF_CTRL: begin
                rdata_nxt[AFR_POS_INT_EN] = int_en_r;
            end
            AFR_OFS_STATUS: begin
                rdata_nxt[7:0] = status_byte;
            end
            AFR_OFS_IRQ_STAT: begin
                rdata_nxt[AFR_POS_DIFF_FLAG +: 4] = irq_stat_r;
            end
            AFR_OFS_IRQ_EN: begin
                rdata_nxt[AFR_POS_DIFF_FLAG +: 4] = irq_en_r;
            end
            AFR_OFS_CONV_CTRL: begin
                rdata_nxt[AFR_POS_CONV_RUN] = run_r;
            end
            default: begin
                rdata_nxt = '0;
            end
        endcase
    end

    // data stands for one cycle only, zero otherwise
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule // afr_core

// ---- core/afr_pkg.sv ----
// package: constants and types for the fault alarm and reference select block
package afr_pkg;

    // register offsets (byte addresses)
    localparam logic [7:0] AFR_OFS_FIRST_MODE = 8'h00;
    localparam logic [7:0] AFR_OFS_REF_SEL    = 8'h04;
    localparam logic [7:0] AFR_OFS_REF_CTRL   = 8'h08;
    localparam logic [7:0] AFR_OFS_STATUS     = 8'h0C;
    localparam logic [7:0] AFR_OFS_IRQ_STAT   = 8'h10;
    localparam logic [7:0] AFR_OFS_IRQ_EN     = 8'h14;
    localparam logic [7:0] AFR_OFS_IRQ_CLR    = 8'h18;
    localparam logic [7:0] AFR_OFS_CONV_CTRL  = 8'h1C;

    // field positions
    localparam int AFR_POS_REF_SWAP  = 7;
    localparam int AFR_POS_POS_SEL   = 3;
    localparam int AFR_POS_NEG_SEL   = 0;
    localparam int AFR_POS_INT_EN    = 0;
    localparam int AFR_POS_DIFF_FLAG = 1;
    localparam int AFR_POS_HIGH_FLAG = 2;
    localparam int AFR_POS_LOW_FLAG  = 3;
    localparam int AFR_POS_REF_FLAG  = 4;
    localparam int AFR_POS_CONV_RUN  = 0;

    // reset values
    localparam logic [2:0] AFR_SEL_INTERNAL = 3'h0;
    localparam logic       AFR_RST_INT_EN   = 1'b1;
    localparam logic       AFR_RST_SWAP     = 1'b0;

    // modulator rate: converter clock divided by this
    localparam int AFR_MOD_DIV = 8;

    // reference source encodings
    typedef enum logic [2:0] {
        AFR_REF_INT   = 3'h0,
        AFR_REF_EXT0  = 3'h1,
        AFR_REF_EXT1  = 3'h2,
        AFR_REF_EXT2  = 3'h3,
        AFR_REF_SUPPLY = 3'h4
    } afr_ref_src_t;

    // comparator inputs from the analog monitors
    typedef struct packed {
        logic ref_low;
        logic amp_low;
        logic amp_high;
        logic diff_over;
    } afr_cmp_t;

    // reference multiplexer settings
    typedef struct packed {
        logic       swap;
        logic [2:0] pos_sel;
        logic [2:0] neg_sel;
        logic       int_en;
    } afr_ref_cfg_t;

endpackage

// ---- core/afr_alarm_latch.sv ----
// file holds one per-conversion sticky alarm latch
`timescale 1ns/10ps
module afr_alarm_latch
    import afr_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // control
    input  wire logic conv_start,
    input  wire logic conv_end,
    input  wire logic cmp,
    // results
    output logic      flag_live,
    output logic      flag_report
);

    logic live_r;
    logic report_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            live_r <= 1'b0;
        end else if (conv_start) begin
            live_r <= cmp;
        end else if (cmp) begin
            live_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            report_r <= 1'b0;
        end else if (conv_end) begin
            report_r <= live_r | cmp;
        end
    end

    assign flag_live   = live_r;
    assign flag_report = report_r;

endmodule // afr_alarm_latch

// ---- dv/afr_core_checker.sv ----
// checker: port-level assertions for the alarm and reference block
`timescale 1ns/10ps
module afr_core_checker
    import afr_pkg::*;
#(
    parameter int DATA_W = 32
) (
    // watched ports
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic [7:0]        reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              conv_start,
    input wire logic              conv_end,
    input wire afr_cmp_t          cmp_in,
    input wire afr_ref_cfg_t      ref_cfg,
    input wire logic [7:0]        status_byte,
    input wire logic              mod_strobe,
    input wire logic              conv_active,
    input wire logic              irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    chk_mod_period: assert property (
        mod_strobe |=> !mod_strobe [*7] ##1 mod_strobe)
        else $error("modulator strobe period wrong");
    // status may only move just after a conversion end
    chk_status_hold: assert property (
        $changed(status_byte) |->
        $past(conv_end) || $past(conv_end, 2) || $past(conv_end, 3))
        else $error("status byte changed outside report");
    chk_status_bits: assert property (
        status_byte[7:5] == 3'h0 && !status_byte[0])
        else $error("status byte unused bit set");
    chk_ref_reset: assert property (
        $fell(rst) |-> ref_cfg ==
        {AFR_RST_SWAP, AFR_SEL_INTERNAL, AFR_SEL_INTERNAL, AFR_RST_INT_EN})
        else $error("reference config not at default");
    chk_irq_cause: assert property (
        $rose(irq) |-> ##[0:3] (status_byte != 8'h00))
        else $error("irq without a reported flag");
    chk_conv_open: assert property (
        conv_start |=> ##1 conv_active)
        else $error("window not open after start");
    chk_sel_follow: assert property (
        reg_wr && reg_addr == AFR_OFS_REF_SEL |=> ##1
        ref_cfg.pos_sel == $past(reg_wdata[5:3], 2) &&
        ref_cfg.neg_sel == $past(reg_wdata[2:0], 2))
        else $error("reference select not applied");
    chk_swap_follow: assert property (
        reg_wr && reg_addr == AFR_OFS_FIRST_MODE |=> ##1
        ref_cfg.swap == $past(reg_wdata[7], 2))
        else $error("polarity swap not applied");
    chk_inten_follow: assert property (
        reg_wr && reg_addr == AFR_OFS_REF_CTRL |=> ##1
        ref_cfg.int_en == $past(reg_wdata[0], 2))
        else $error("internal reference enable not applied");
endmodule // afr_core_checker

bind afr_core afr_core_checker #(.DATA_W(DATA_W)) i_afr_core_checker (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_start(conv_start), .conv_end(conv_end), .cmp_in(cmp_in),
    .ref_cfg(ref_cfg), .status_byte(status_byte), .mod_strobe(mod_strobe),
    .conv_active(conv_active), .irq(irq));

// ---- dv/afr_core_test.sv ----
// testbench: model-checked stimulus for the alarm and reference block
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
    err_total++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module afr_core_test
    import afr_pkg::*;
;
    logic         mclk = 1'b0;
    logic         rst = 1'b1;
    logic [7:0]   reg_addr = 8'h00;
    logic [31:0]  reg_wdata = 32'h0;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [31:0]  reg_rdata;
    logic         conv_start = 1'b0;
    logic         conv_end = 1'b0;
    afr_cmp_t     cmp_in = 4'h0;
    afr_ref_cfg_t ref_cfg;
    logic [7:0]   status_byte;
    logic         mod_strobe;
    logic         conv_active;
    logic         irq;
    int           seed = 46908;
    int           err_total = 0;
    int           n_compared = 0;
    int           n;
    logic [31:0]  d, stat = 32'h0, en = 32'h0, stsb = 32'h0;
    logic [3:0]   acc, c;
    logic [2:0]   ps, ng;
    logic         sw, ie;

    always #5 mclk = ~mclk;

    afr_core #(.DATA_W(32)) i_afr_core (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .conv_start(conv_start), .conv_end(conv_end), .cmp_in(cmp_in),
        .ref_cfg(ref_cfg), .status_byte(status_byte),
        .mod_strobe(mod_strobe), .conv_active(conv_active), .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (err_total == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg_rdata", e, reg_rdata)
    endtask

    // start and end edges both count toward the flags
    task automatic conv(input int len, input logic [3:0] msk);
        acc = 4'h0;
        for (int i = 0; i <= len; i++) begin
            @(posedge mclk);
            c = 4'($random(seed)) & 4'($random(seed)) & msk;
            conv_start <= (i == 0);
            conv_end   <= (i == len);
            cmp_in     <= c;
            acc = acc | c;
        end
        @(posedge mclk);
        conv_end <= 1'b0;
        // noise outside the window must be ignored
        cmp_in <= 4'($random(seed));
        stsb = {27'h0, acc, 1'b0};
        stat = stat | stsb;
        repeat (3) @(posedge mclk);
        #1;
        `CHK("status_byte", stsb[7:0], status_byte)
        `CHK("irq", |(stat & en), irq)
        rd(AFR_OFS_IRQ_STAT, stat);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'(a == 8));
        `CHK("ref_cfg", 8'h01, ref_cfg)
        for (int k = 0; k < 12; k++) begin
            d  = $random(seed);
            ps = 3'(k % 5);
            ng = 3'((k + 1) % 5);
            // swap only with external pairs, off while selects move
            sw = (d[7] || k[0]) && ps inside {[3'h1:3'h3]} &&
                 ng inside {[3'h1:3'h3]};
            ie = d[0];
            wr(AFR_OFS_FIRST_MODE, 32'h0);
            wr(AFR_OFS_REF_SEL, {d[31:6], ps, ng});
            wr(AFR_OFS_FIRST_MODE, {d[31:8], sw, d[6:0]});
            wr(AFR_OFS_REF_CTRL, d);
            rd(AFR_OFS_REF_SEL, {26'h0, ps, ng});
            rd(AFR_OFS_FIRST_MODE, {24'h0, sw, 7'h0});
            rd(AFR_OFS_REF_CTRL, {31'h0, ie});
            `CHK("ref_cfg", {sw, ps, ng, ie}, ref_cfg)
        end
        wr(AFR_OFS_FIRST_MODE, 32'h0);
        wr(AFR_OFS_REF_SEL, 32'h0);
        // reference powered well before any conversion
        wr(AFR_OFS_REF_CTRL, 32'h1);
        wr(AFR_OFS_STATUS, 32'hFFFFFFFF);
        rd(AFR_OFS_STATUS, 32'h0);
        `CHK("ref_cfg", 8'h01, ref_cfg)
        wr(AFR_OFS_CONV_CTRL, 32'h1);
        rd(AFR_OFS_CONV_CTRL, 32'h1);
        `CHK("conv_active", 1'b1, conv_active)
        wr(AFR_OFS_CONV_CTRL, 32'h0);
        rd(AFR_OFS_CONV_CTRL, 32'h0);
        `CHK("conv_active", 1'b0, conv_active)
        n = 0;
        repeat (80) begin
            @(posedge mclk);
            #1;
            if (mod_strobe === 1'b1) n++;
        end
        `CHK("mod_strobe", 10, n)
        en = 32'h1E;
        wr(AFR_OFS_IRQ_EN, 32'hFFFFFFFF);
        rd(AFR_OFS_IRQ_EN, en);
        for (int k = 0; k < 16; k++) begin
            conv(1 + k % 8, (k % 3 == 0) ? 4'h0 : 4'($random(seed)));
            if (k % 4 == 3) begin
                d = $random(seed);
                wr(AFR_OFS_IRQ_CLR, d);
                stat = stat & ~d;
                rd(AFR_OFS_IRQ_CLR, 32'h0);
                rd(AFR_OFS_IRQ_STAT, stat);
                `CHK("irq", |(stat & en), irq)
            end
        end
        conv(3, 4'hF);
        // a lone end pulse must leave the report untouched
        @(posedge mclk);
        conv_end <= 1'b1;
        cmp_in   <= 4'hF;
        @(posedge mclk);
        conv_end <= 1'b0;
        cmp_in   <= 4'h0;
        repeat (3) @(posedge mclk);
        #1;
        `CHK("status_byte", stsb[7:0], status_byte)
        `CHK("irq", |(stat & en), irq)
        conv(4, 4'h0);
        wr(AFR_OFS_IRQ_EN, 32'h0);
        en = 32'h0;
        rd(AFR_OFS_IRQ_EN, en);
        `CHK("irq", 1'b0, irq)
        tally_and_finish();
    end
endmodule // afr_core_test
